// [hw/acs_pkg.sv]
// constants and types shared by the conversion sequencer files
package acs_pkg;
    // register map, 8-bit wide registers
    localparam logic [7:0] REG_DELAY    = 8'h03; // settling delay, mod periods
    localparam logic [7:0] REG_DATARATE = 8'h04; // chop, filter, mode bits
    localparam logic [7:0] REG_PER_LO   = 8'h20; // data period low byte
    localparam logic [7:0] REG_PER_HI   = 8'h21; // data period high byte
    localparam logic [7:0] REG_STATUS   = 8'h22; // sequencer state
    localparam logic [7:0] REG_RES_LO   = 8'h23; // result low byte, clears new
    localparam logic [7:0] REG_RES_HI   = 8'h24; // result high byte

    // field positions in the data rate register
    localparam int CHOP_BIT   = 5;               // global chop enable
    localparam int FILT_BIT   = 4;               // 1 low latency, 0 sinc cubed
    localparam int SINGLE_BIT = 3;               // 1 single shot

    // status register field positions
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_NEW_BIT  = 1;
    localparam int ST_POL_BIT  = 2;
    localparam int ST_SET_BIT  = 3;

    // reset values
    localparam logic [7:0]  DELAY_RST    = 8'h0e;   // fourteen mod periods
    localparam logic [7:0]  DATARATE_RST = 8'h10;   // low latency, continuous
    localparam logic [15:0] PERIOD_RST   = 16'h0040; // data period, mod periods

    // timing
    localparam logic [3:0]  MOD_DIV_LAST = 4'hf;    // sixteen clocks per period
    localparam logic [15:0] OVH_PERIODS  = 16'h0004; // result overhead
    localparam logic [1:0]  NEED_LL      = 2'h1;    // periods to settle
    localparam logic [1:0]  NEED_SINC3   = 2'h3;

    // serial start command, first seven bits as shifted in msb first
    localparam logic [6:0]  CMD_START_HI7 = 7'h05;
    localparam logic [2:0]  CMD_LAST_BIT  = 3'h6;   // index of seventh bit

    // pin synchroniser
    localparam int          SYNC_W   = 4;
    localparam logic [3:0]  SYNC_RST = 4'he;        // data, select, clock idle high
    localparam int          PIN_START = 0;
    localparam int          PIN_SCLK  = 1;
    localparam int          PIN_CSN   = 2;
    localparam int          PIN_SDI   = 3;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_DELAY  = 2'b01,
        ST_SAMPLE = 2'b10,
        ST_OVH    = 2'b11
    } acs_state_e;
endpackage : acs_pkg

// [hw/acs_sync_if.sv]
// pin bundle passed between the sequencer and its synchroniser
`timescale 1ns/1ps
`default_nettype none
interface acs_sync_if;
    logic [acs_pkg::SYNC_W-1:0] raw;    // pins as they arrive
    logic [acs_pkg::SYNC_W-1:0] synced; // pins after two flops
    modport src (output raw, input synced);
    modport dst (input raw, output synced);
endinterface : acs_sync_if
`default_nettype wire

// [hw/acs_sync2.sv]
// two-flop synchroniser for the asynchronous pins
`timescale 1ns/1ps
`default_nettype none
module acs_sync2 (
    input  wire logic sys_clk, // system clock
    input  wire logic rstn,    // async reset, active low
    input  wire logic clk_en,  // freezes state when low
    acs_sync_if.dst   sif      // raw pins in, synced pins out
);
    import acs_pkg::*;

    logic [SYNC_W-1:0] meta_r; // first stage, read only by stab_r
    logic [SYNC_W-1:0] stab_r; // second stage

    ////////////////////////////////////////////////////////////////////////
    // two stages; nothing but stab_r looks at meta_r
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            meta_r <= SYNC_RST;
            stab_r <= SYNC_RST;
        end else if (clk_en) begin
            meta_r <= sif.raw;
            stab_r <= meta_r;
        end
    end

    assign sif.synced = stab_r;
endmodule : acs_sync2
`default_nettype wire

// [hw/acs_sequencer.sv]
// conversion timing sequencer: start detect, delay, settling, chop average
`timescale 1ns/1ps
`default_nettype none
module acs_sequencer (
    input  wire logic        sys_clk,   // 25 MHz system clock
    input  wire logic        rstn,      // async reset, active low
    input  wire logic        clk_en,    // freezes all state when low, except data_valid which clears
    input  wire logic        start_pin, // start/sync pin, asynchronous
    input  wire logic        sclk,      // serial clock pin, asynchronous
    input  wire logic        cs_n,      // serial select, active low
    input  wire logic        sdi,       // serial data in
    input  wire logic [15:0] filt_data, // filter output, same clock
    input  wire logic [7:0]  reg_addr,  // register address
    input  wire logic [7:0]  reg_wdata, // register write data
    input  wire logic        reg_wr,    // write strobe
    input  wire logic        reg_rd,    // read strobe
    output logic      [7:0]  reg_rdata, // read data, cycle after strobe
    output logic             chop_rev,  // input polarity reversed
    output logic             conv_busy, // sequence running
    output logic      [15:0] data_out,  // latest readable result
    output logic             data_valid // one-cycle pulse per result
);
    import acs_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisation and edge finding
    acs_sync_if sif ();
    assign sif.raw = {sdi, cs_n, sclk, start_pin};

    acs_sync2 u_sync (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .clk_en  (clk_en),
        .sif     (sif)
    );

    logic [SYNC_W-1:0] pin_prev_r;   // synced pins one cycle back
    logic [2:0]        bit_cnt_r;    // falling edges in current byte
    logic [5:0]        cmd_sh_r;     // command bits so far

    wire start_rise = sif.synced[PIN_START] & ~pin_prev_r[PIN_START];
    wire sclk_fall  = ~sif.synced[PIN_SCLK] & pin_prev_r[PIN_SCLK];
    wire sel        = ~sif.synced[PIN_CSN];
    wire cmd_edge   = sclk_fall & sel;
    // seventh falling edge of a start command
    wire cmd_start  = cmd_edge && (bit_cnt_r == CMD_LAST_BIT)
                    && ({cmd_sh_r, sif.synced[PIN_SDI]} == CMD_START_HI7);
    wire start_evt  = start_rise | cmd_start;

    // edge history and command shifter
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pin_prev_r <= SYNC_RST;
            bit_cnt_r  <= '0;
            cmd_sh_r   <= '0;
        end else if (clk_en) begin
            pin_prev_r <= sif.synced;
            if (!sel) begin
                bit_cnt_r <= '0;           // deselect restarts byte framing
            end else if (cmd_edge) begin
                bit_cnt_r <= bit_cnt_r + 3'h1;
                cmd_sh_r  <= {cmd_sh_r[4:0], sif.synced[PIN_SDI]};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers
    logic [7:0]  delay_r;    // settling delay in modulator periods
    logic [7:0]  rate_r;     // chop, filter and mode bits
    logic [15:0] period_r;   // data period in modulator periods
    logic        new_r;      // unread result waiting

    wire wr_delay = reg_wr && (reg_addr == REG_DELAY);
    wire wr_rate  = reg_wr && (reg_addr == REG_DATARATE);
    wire wr_plo   = reg_wr && (reg_addr == REG_PER_LO);
    wire wr_phi   = reg_wr && (reg_addr == REG_PER_HI);
    wire rd_res   = reg_rd && (reg_addr == REG_RES_LO);

    wire chop_en  = rate_r[CHOP_BIT];
    wire filt_ll  = rate_r[FILT_BIT];
    wire single   = rate_r[SINGLE_BIT];

    // software writes
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            delay_r  <= DELAY_RST;
            rate_r   <= DATARATE_RST;
            period_r <= PERIOD_RST;
        end else if (clk_en) begin
            if (wr_delay) delay_r         <= reg_wdata;
            if (wr_rate)  rate_r          <= reg_wdata;
            if (wr_plo)   period_r[7:0]   <= reg_wdata;
            if (wr_phi)   period_r[15:8]  <= reg_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // modulator tick: one per sixteen clocks
    logic [3:0] pre_r;
    wire        tick = (pre_r == MOD_DIV_LAST);

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) pre_r <= '0;
        else if (clk_en) pre_r <= pre_r + 4'h1;
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencer state
    acs_state_e  state_r, state_nxt;
    logic [15:0] cnt_r, cnt_nxt;      // mod periods left in this state
    logic [1:0]  set_cnt_r;           // settled periods in this polarity
    logic        ovh_done_r;          // overhead already paid
    logic        pol_r;               // reversed polarity active
    logic        have_prev_r;         // other polarity value held
    logic [15:0] prev_r;              // corrected other-polarity value
    logic [15:0] pend_r;              // result waiting for overhead

    wire [1:0]  need      = filt_ll ? NEED_LL : NEED_SINC3;
    wire [2:0]  set_next  = {1'b0, set_cnt_r} + 3'h1;
    wire        phase_ok  = (set_next >= {1'b0, need});
    wire        samp_end  = (state_r == ST_SAMPLE) && tick && (cnt_r == 16'h1);
    wire        ovh_end   = (state_r == ST_OVH) && tick && (cnt_r == 16'h1);
    wire        dly_end   = (state_r == ST_DELAY) && tick && (cnt_r == 16'h1);
    // reversed conversions are negated so averaging cancels the offset
    wire [15:0] corr      = pol_r ? 16'(-filt_data) : filt_data;
    wire [16:0] sum       = {prev_r[15], prev_r} + {corr[15], corr};
    wire [15:0] avg       = sum[16:1];
    wire        avail     = phase_ok && (!chop_en || have_prev_r);
    wire        out_now   = (samp_end && avail && ovh_done_r) || ovh_end;
    // delay of zero goes straight to sampling
    wire        dly_zero  = (delay_r == 8'h0);
    wire acs_state_e dly_st = dly_zero ? ST_SAMPLE : ST_DELAY;
    wire [15:0] dly_cnt   = dly_zero ? period_r : {8'h0, delay_r};
    wire acs_state_e run_st = chop_en ? dly_st : ST_SAMPLE;
    wire [15:0] run_cnt   = chop_en ? dly_cnt : period_r;

    // next state
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        if (start_evt) begin
            state_nxt = dly_st;
            cnt_nxt   = dly_cnt;
        end else if (tick) begin
            case (state_r)
                ST_IDLE: begin
                    state_nxt = ST_IDLE;     // waits for a start
                end
                ST_DELAY: begin
                    if (dly_end) begin
                        state_nxt = ST_SAMPLE;
                        cnt_nxt   = period_r;
                    end else begin
                        cnt_nxt = cnt_r - 16'h1;
                    end
                end
                ST_SAMPLE: begin
                    if (!samp_end) begin
                        cnt_nxt = cnt_r - 16'h1;
                    end else if (!phase_ok) begin
                        cnt_nxt = period_r;  // hidden, no overhead
                    end else if (avail && !ovh_done_r) begin
                        state_nxt = ST_OVH;  // first readable only
                        cnt_nxt   = OVH_PERIODS;
                    end else if (avail && single) begin
                        state_nxt = ST_IDLE;
                    end else if (chop_en) begin
                        state_nxt = dly_st;  // next polarity
                        cnt_nxt   = dly_cnt;
                    end else begin
                        cnt_nxt = period_r;  // one data period each
                    end
                end
                ST_OVH: begin
                    if (ovh_end) begin
                        state_nxt = single ? ST_IDLE : run_st;
                        cnt_nxt   = run_cnt;
                    end else begin
                        cnt_nxt = cnt_r - 16'h1;
                    end
                end
                default: begin
                    state_nxt = ST_IDLE;
                end
            endcase
        end
    end

    // state and count
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_r <= ST_IDLE;
            cnt_r   <= '0;
        end else if (clk_en) begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
        end
    end

    // settling, polarity and chop pipeline
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            set_cnt_r   <= '0;
            ovh_done_r  <= 1'b0;
            pol_r       <= 1'b0;
            have_prev_r <= 1'b0;
            prev_r      <= '0;
            pend_r      <= '0;
        end else if (clk_en) begin
            if (start_evt) begin
                set_cnt_r   <= '0;
                ovh_done_r  <= 1'b0;
                pol_r       <= 1'b0;         // normal polarity first
                have_prev_r <= 1'b0;
            end else if (samp_end) begin
                if (!phase_ok) begin
                    set_cnt_r <= set_next[1:0];
                end else if (chop_en) begin
                    // each polarity resettles, so the first result needs twice the settling
                    set_cnt_r   <= '0;
                    pol_r       <= ~pol_r;
                    prev_r      <= corr;
                    have_prev_r <= 1'b1;
                end
                if (avail) begin
                    pend_r <= chop_en ? avg : filt_data;
                end
            end else if (ovh_end) begin
                ovh_done_r <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // result output
    wire [15:0] res_val = ovh_end ? pend_r : (chop_en ? avg : filt_data);

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            data_out   <= '0;
            data_valid <= 1'b0;
            new_r      <= 1'b0;
        end else if (clk_en) begin
            data_valid <= out_now;
            if (out_now) data_out <= res_val;
            // a result in the reading cycle stays flagged
            if (out_now) new_r <= 1'b1;
            else if (rd_res) new_r <= 1'b0;
        end else begin
            data_valid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register read port
    wire [7:0] status = {4'h0, (set_cnt_r != 2'h0) | ovh_done_r, pol_r,
                         new_r, conv_busy};
    wire [7:0] rd_mux =
        (reg_addr == REG_DELAY)    ? delay_r :
        (reg_addr == REG_DATARATE) ? rate_r :
        (reg_addr == REG_PER_LO)   ? period_r[7:0] :
        (reg_addr == REG_PER_HI)   ? period_r[15:8] :
        (reg_addr == REG_STATUS)   ? status :
        (reg_addr == REG_RES_LO)   ? data_out[7:0] :
        (reg_addr == REG_RES_HI)   ? data_out[15:8] : 8'h00;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) reg_rdata <= '0;
        else if (clk_en) reg_rdata <= reg_rd ? rd_mux : 8'h00;
    end

    assign chop_rev  = pol_r;
    assign conv_busy = (state_r != ST_IDLE);

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    AST_START_DELAY: assert property (
        clk_en && start_evt && !dly_zero |=> state_r == ST_DELAY
            && cnt_r == {8'h0, $past(delay_r)})
        else $error("start did not load the settling delay");
    AST_FIRST_OVH: assert property (
        clk_en && samp_end && avail && !ovh_done_r |=> state_r == ST_OVH
            && cnt_r == OVH_PERIODS)
        else $error("first result skipped its overhead");
    AST_PIN_START: assert property (
        clk_en && start_rise |=> conv_busy)
        else $error("pin rise did not start a sequence");
    AST_SETTLED: assert property (
        out_now && !filt_ll |-> ovh_end || set_cnt_r == 2'h2)
        else $error("sinc cubed result before settling");
    AST_HIDDEN: assert property (
        clk_en && samp_end && !phase_ok |=> !data_valid)
        else $error("unsettled result was shown");
    AST_NO_OVH_HIDDEN: assert property (
        clk_en && samp_end && !phase_ok |=> state_r == ST_SAMPLE
            && cnt_r == $past(period_r))
        else $error("hidden result took overhead");
    AST_POL_FLIP: assert property (
        clk_en && samp_end && phase_ok && chop_en && !start_evt
            |=> pol_r != $past(pol_r))
        else $error("polarity did not reverse");
    AST_CHOP_PAIR: assert property (
        out_now && chop_en && !ovh_end |-> have_prev_r)
        else $error("chop result without both polarities");
    AST_AVG: assert property (
        clk_en && out_now && chop_en && !ovh_end |=> data_out == $past(avg))
        else $error("chop result is not the average");
    AST_CHOP_BIT: assert property (
        clk_en && wr_rate |=> chop_en == $past(reg_wdata[CHOP_BIT]))
        else $error("chop bit not taken from 04h");

    COV_FIRST: cover property (data_valid && !chop_en);
    COV_CHOP: cover property (data_valid && chop_en);
    COV_CMD: cover property (cmd_start);
    COV_SINC3: cover property (data_valid && !filt_ll);
endmodule : acs_sequencer
`default_nettype wire

// [tb/acs_host_model.sv]
// host side model: drives the start pin and the serial start command
`timescale 1ns/1ps
`default_nettype none
module acs_host_model (
    input  wire logic sys_clk,   // system clock, paces the pins
    output var  logic start_pin, // start/sync pin
    output var  logic sclk,      // serial clock, still high outside frames
    output var  logic cs_n,      // serial select, active low
    output var  logic sdi        // serial data, msb first
);
    // idle pins: select high, clock parked high
    initial begin
        start_pin = 1'b0;
        sclk      = 1'b1;
        cs_n      = 1'b1;
        sdi       = 1'b1;
    end
    ////////////////////////////////////////
    // pulse held well past the two-flop synchroniser
    task automatic pulse_start;
        start_pin <= 1'b1; // rising edge starts a sequence
        repeat (6) @(posedge sys_clk);
        start_pin <= 1'b0;
        repeat (6) @(posedge sys_clk);
    endtask : pulse_start
    // one byte msb first, 320 ns clock; data set while clock high
    task automatic send_byte(input logic [7:0] b);
        int i;
        cs_n <= 1'b0;
        for (i = 7; i >= 0; i--) begin
            sdi <= b[i];
            repeat (4) @(posedge sys_clk);
            sclk <= 1'b0; // seventh fall starts a conversion
            repeat (4) @(posedge sys_clk);
            sclk <= 1'b1;
        end
        repeat (4) @(posedge sys_clk);
        cs_n <= 1'b1;
        sdi  <= ~b[0]; // released line must not echo the last bit
    endtask : send_byte
endmodule : acs_host_model
`default_nettype wire

// [tb/tb.sv]
// self-checking bench for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
    import acs_pkg::*;
    logic               sys_clk, rstn, clk_en;     // clock, reset, enable
    wire logic          start_pin, sclk, cs_n, sdi; // from the host model
    logic        [15:0] filt_data, data_out;       // filter in, result out
    logic        [7:0]  reg_addr, reg_wdata, reg_rdata; // register bus
    logic               reg_wr, reg_rd;            // bus strobes
    logic               chop_rev, conv_busy, data_valid; // status outputs
    logic               busy_q;                    // busy one cycle ago
    logic signed [15:0] sig_v, ofs_v;              // true input, offset
    int                 miscompares, samples_checked, cyc, t_busy, seed, i;
    int                 tq[$];                     // cycle of each result
    logic        [15:0] dq[$];                     // value of each result
    logic        [7:0]  rate_t[6] = '{8'h10, 8'h00, 8'h18, 8'h08,
                                      8'h30, 8'h20};
    int                 d_t[6]    = '{2, 2, 0, 1, 2, 14};
    int                 p_t[6]    = '{3, 3, 3, 2, 3, 2};
    int                 n_t[6]    = '{3, 3, 1, 1, 3, 3};

    acs_sequencer DUT (.sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en),
        .start_pin(start_pin), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
        .filt_data(filt_data), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .chop_rev(chop_rev), .conv_busy(conv_busy), .data_out(data_out),
        .data_valid(data_valid));
    acs_host_model host (.sys_clk(sys_clk), .start_pin(start_pin),
        .sclk(sclk), .cs_n(cs_n), .sdi(sdi));

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    ////////////////////////////////////////
    // filter model: offset stays, signal flips with polarity; log results
    always @(posedge sys_clk) begin
        cyc       <= cyc + 1;
        busy_q    <= conv_busy;
        filt_data <= (chop_rev === 1'b1) ? ofs_v - sig_v : ofs_v + sig_v;
        if (conv_busy === 1'b1 && busy_q !== 1'b1) t_busy <= cyc;
        if (data_valid === 1'b1) begin
            tq.push_back(cyc);
            dq.push_back(data_out);
        end
    end
    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk_val
    // pace check: prescaler phase is arbitrary, so a one-tick window for the first result, exact spacing after it
    task automatic chk_time(input int got, input int lo, input int hi);
        samples_checked++;
        if (got < lo || got > hi) begin
            miscompares++;
            $display("[FAIL] %0t got %h exp %h", $time, got, lo);
        end
    endtask : chk_time
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        @(posedge sys_clk);
    endtask : wr
    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 chk_val({8'h00, reg_rdata}, {8'h00, exp});
        @(posedge sys_clk);
    endtask : rd
    task automatic do_reset;
        rstn <= 1'b0;
        repeat (6) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
    endtask : do_reset
    task automatic wait_res(input int n);
        int k;
        for (k = 0; k < 20000 && tq.size() < n; k++) @(posedge sys_clk);
        if (tq.size() < n) begin
            miscompares++;
            $display("[FAIL] %0t got %h exp %h", $time, tq.size(), n);
            wrap_up();
        end
    endtask : wait_res
    ////////////////////////////////////////
    // one sequence from reset: program, start, check value and pace
    task automatic run(input logic [7:0] rate, input int d, input int p,
                       input int n, input bit by_cmd);
        int need, first, next, k;
        logic [15:0] ev;
        need  = rate[FILT_BIT] ? 1 : 3;
        first = d + need * p + 4;  // hidden results carry no overhead
        next  = p;
        if (rate[CHOP_BIT]) begin
            first = 2 * (d + need * p) + 4;
            next  = d + need * p;
        end
        sig_v = 16'($random(seed) % 4000);
        ofs_v = 16'($random(seed) % 500);
        ev    = rate[CHOP_BIT] ? sig_v : sig_v + ofs_v;
        do_reset();
        wr(REG_DELAY, d[7:0]);
        wr(REG_PER_LO, p[7:0]);
        wr(REG_PER_HI, 8'h00);
        wr(REG_DATARATE, rate);
        tq.delete();
        dq.delete();
        if (by_cmd) host.send_byte(8'h0a);
        else host.pulse_start();
        wait_res(n);
        chk_time(tq[0] - t_busy, 16*first - 16, 16*first);
        for (k = 1; k < n; k++)
            chk_time(tq[k] - tq[k-1], 16 * next, 16 * next);
        for (k = 0; k < n; k++)
            chk_val(dq[k], ev);
        if (rate[SINGLE_BIT]) begin
            repeat (16 * (first + 4)) @(posedge sys_clk);
            chk_val(16'(tq.size()), 16'h0001);
            chk_val({15'h0000, conv_busy}, 16'h0000);
            // idle, overhead paid, result unread; reading low byte clears it
            rd(REG_STATUS, 8'h0a);
            rd(REG_RES_LO, ev[7:0]);
            rd(REG_RES_HI, ev[15:8]);
            rd(REG_STATUS, 8'h08);
        end
    endtask : run
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : wrap_up
    ////////////////////////////////////////
    // main sequence: register map, then both filters in each mode, and chop in continuous mode only
    initial begin
        seed = 32'h661a;
        {rstn, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        {miscompares, samples_checked, cyc, t_busy} = '0;
        {sig_v, ofs_v, filt_data, busy_q} = '0;
        clk_en = 1'b1;
        do_reset();
        rd(REG_DELAY, 8'h0e);
        rd(REG_DATARATE, 8'h10);
        rd(REG_PER_LO, 8'h40);
        rd(8'h55, 8'h00);
        // enable low freezes the registers, so this write must not land
        clk_en <= 1'b0;
        wr(REG_DELAY, 8'h55);
        clk_en <= 1'b1;
        rd(REG_DELAY, 8'h0e);
        wr(REG_DATARATE, 8'h20);
        rd(REG_DATARATE, 8'h20);
        for (i = 0; i < 6; i++)
            run(rate_t[i], d_t[i], p_t[i], n_t[i], i[0]);
        wrap_up();
    end
endmodule : tb
`default_nettype wire
